// ===== rsm_pkg.sv
// Package for the regulator status and interrupt mask register bank.
// Assumes an 8-bit register port driven by the serial interface engine.
package rsm_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_TOP_FLAGS      = 8'h18;
   localparam logic [7:0] ADDR_RESET_FLAGS    = 8'h19;
   localparam logic [7:0] ADDR_SWITCHER_STAT  = 8'h1e;
   localparam logic [7:0] ADDR_LINREG_STAT    = 8'h1f;
   localparam logic [7:0] ADDR_TOP_MASK       = 8'h20;
   localparam logic [7:0] ADDR_RESET_MASK     = 8'h21;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SW0_INVALID_BIT     = 2;
   localparam int SW0_ILIM_BIT        = 0;
   localparam int LIN1_EN_BIT         = 7;
   localparam int LIN1_INVALID_BIT    = 6;
   localparam int LIN1_ILIM_BIT       = 4;
   localparam int LIN0_EN_BIT         = 3;
   localparam int LIN0_INVALID_BIT    = 2;
   localparam int LIN0_ILIM_BIT       = 0;
   localparam int PGOOD_BIT           = 7;
   localparam int SYNC_CLK_BIT        = 4;
   localparam int THERMAL_BIT         = 2;
   localparam int LOAD_MEAS_BIT       = 0;
   localparam int REG_RESET_BIT       = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] TOP_MASK_RESET   = 8'h90;
   localparam logic [7:0] RESET_MASK_RESET = 8'h01;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // Which top mask bits are live event gates
   localparam logic [7:0] TOP_EVENT_BITS   = 8'h95;

endpackage

// ===== rsm_flag.sv
// Single latched interrupt flag with write-one-to-clear.
// Assumes set and clear are synchronous one-cycle strobes.
`timescale 1ns/1ps

module rsm_flag
   import rsm_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // Event and clear
   input  wire logic set_evt,
   input  wire logic clr_evt,
   // Latched state
   output logic      flag
);

   logic next_flag;

   // Set beats clear so an event in the clearing cycle survives
   always_comb
   begin
      next_flag = flag;
      if (set_evt)
      begin
         next_flag = 1'b1;                  // R13
      end
      else if (clr_evt)
      begin
         next_flag = 1'b0;                  // R13
      end
   end

   // Flag register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flag <= 1'b0;
      end
      else
      begin
         flag <= next_flag;
      end
   end

endmodule

// ===== rsm_regs.sv
// Regulator status, event flags and interrupt mask registers.
// Assumes the serial interface engine presents single-cycle read and
// write strobes on an 8-bit register port, synchronous to ref_clk.
`timescale 1ns/1ps

// Behaviour
// R1 - Switcher status bit 2 shows converter 0 output invalid, read-only, zero at reset.
// R2 - Switcher status bit 0 shows converter 0 current limit, read-only, zero at reset.
// R3 - Linear status bits 7 and 3 show regulator 1 and 0 enable state.
// R4 - Linear status bits 6 and 2 show regulator 1 and 0 output invalid.
// R5 - Linear status bits 4 and 0 show regulator 1 and 0 current limit.
// R6 - Top mask bit 7 gates power-good interrupt; one suppresses; resets to one.
// R7 - Top mask bit 4 gates sync-clock detection interrupt; resets to one.
// R8 - Top mask bit 2 gates thermal warning interrupt; resets to zero.
// R9 - Top mask bit 0 gates load-measurement-ready interrupt; resets to zero.
// R10 - Masks only gate interrupts; raw status always tracks its condition.
// R11 - Reset mask bit 0 gates register-reset interrupt, defaults one, bits 7:1 reserved.
// R12 - Host writes to reset mask bit leave no effect; reloaded from OTP.
// R13 - Flags latch on their event; host clears a flag by writing one.
// R14 - Interrupt output high while any unmasked latched flag is set.
module rsm_regs
   import rsm_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   // Raw switcher condition
   input  wire logic       sw0_output_invalid,
   input  wire logic       sw0_current_limited,
   // Raw linear regulator condition
   input  wire logic       linreg1_enabled,
   input  wire logic       linreg1_output_invalid,
   input  wire logic       linreg1_current_limited,
   input  wire logic       linreg0_enabled,
   input  wire logic       linreg0_output_invalid,
   input  wire logic       linreg0_current_limited,
   // Event strobes
   input  wire logic       power_good_event,
   input  wire logic       sync_clk_event,
   input  wire logic       thermal_warning_event,
   input  wire logic       load_meas_event,
   input  wire logic       reg_reset_event,
   // One-time-programmable mask value
   input  wire logic       otp_reset_irq_mask,
   // Interrupt
   output logic            irq
);

   // ----------------------------------------------------------------
   // Address decode helper
   // ----------------------------------------------------------------

   // Write strobe aimed at one register
   function automatic logic wr_hit(input logic [7:0] addr, input logic wr,
                                   input logic [7:0] target);
      wr_hit = wr && (addr == target);
   endfunction

   // ----------------------------------------------------------------
   // Mask registers
   // ----------------------------------------------------------------

   logic [7:0] top_event_mask;
   logic [7:0] next_top_event_mask;
   logic [7:0] reset_event_mask;
   logic [7:0] next_reset_event_mask;
   logic       otp_loaded;
   logic       next_otp_loaded;

   logic       power_good_irq_mask;
   logic       sync_clk_irq_mask;
   logic       thermal_warning_irq_mask;
   logic       load_meas_irq_mask;
   logic       reset_irq_mask;

   // Reserved mask bits are plain storage so read-back matches writes
   always_comb
   begin
      next_top_event_mask   = top_event_mask;
      next_reset_event_mask = reset_event_mask;
      next_otp_loaded       = 1'b1;
      if (wr_hit(reg_addr, reg_wr, ADDR_TOP_MASK))
      begin
         next_top_event_mask = reg_wdata;                      // R6 R7 R8 R9
      end
      if (wr_hit(reg_addr, reg_wr, ADDR_RESET_MASK))
      begin
         // Only the reserved upper bits take the host value
         next_reset_event_mask[7:1] = reg_wdata[7:1];          // R11
      end
      // Bit 0 follows OTP once, right after reset release
      if (!otp_loaded)
      begin
         next_reset_event_mask[REG_RESET_BIT] = otp_reset_irq_mask; // R12
      end
   end

   // Mask storage; the OTP bit is sampled after release, never at reset
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         top_event_mask   <= TOP_MASK_RESET;                   // R6 R7 R8 R9
         reset_event_mask <= RESET_MASK_RESET;                 // R11
         otp_loaded       <= 1'b0;
      end
      else
      begin
         top_event_mask   <= next_top_event_mask;
         reset_event_mask <= next_reset_event_mask;
         otp_loaded       <= next_otp_loaded;
      end
   end

   // Named views of the live gate bits
   assign power_good_irq_mask      = top_event_mask[PGOOD_BIT];
   assign sync_clk_irq_mask        = top_event_mask[SYNC_CLK_BIT];
   assign thermal_warning_irq_mask = top_event_mask[THERMAL_BIT];
   assign load_meas_irq_mask       = top_event_mask[LOAD_MEAS_BIT];
   assign reset_irq_mask           = reset_event_mask[REG_RESET_BIT];

   // ----------------------------------------------------------------
   // Latched event flags
   // ----------------------------------------------------------------

   logic power_good_flag;
   logic sync_clk_flag;
   logic thermal_warning_flag;
   logic load_meas_ready_flag;
   logic reg_reset_flag;
   logic top_clr;
   logic reset_clr;

   // Write-one-to-clear strobes
   assign top_clr   = wr_hit(reg_addr, reg_wr, ADDR_TOP_FLAGS);
   assign reset_clr = wr_hit(reg_addr, reg_wr, ADDR_RESET_FLAGS);

   // Flags latch even while masked, so unmasking later reveals history
   rsm_flag u_flag_pgood
   (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .set_evt (power_good_event),
      .clr_evt (top_clr && reg_wdata[PGOOD_BIT]),               // R13
      .flag    (power_good_flag)
   );

   rsm_flag u_flag_sync
   (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .set_evt (sync_clk_event),
      .clr_evt (top_clr && reg_wdata[SYNC_CLK_BIT]),            // R13
      .flag    (sync_clk_flag)
   );

   rsm_flag u_flag_thermal
   (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .set_evt (thermal_warning_event),
      .clr_evt (top_clr && reg_wdata[THERMAL_BIT]),             // R13
      .flag    (thermal_warning_flag)
   );

   rsm_flag u_flag_meas
   (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .set_evt (load_meas_event),
      .clr_evt (top_clr && reg_wdata[LOAD_MEAS_BIT]),           // R13
      .flag    (load_meas_ready_flag)
   );

   rsm_flag u_flag_reset
   (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .set_evt (reg_reset_event),
      .clr_evt (reset_clr && reg_wdata[REG_RESET_BIT]),         // R13
      .flag    (reg_reset_flag)
   );

   // ----------------------------------------------------------------
   // Status words
   // ----------------------------------------------------------------

   logic [7:0] switcher_status;
   logic [7:0] linear_reg_status;
   logic [7:0] top_flags;
   logic [7:0] reset_flags;

   // Raw conditions pass straight through; no mask bit touches them
   always_comb
   begin
      switcher_status                     = 8'h00;
      switcher_status[SW0_INVALID_BIT]    = sw0_output_invalid;      // R1 R10
      switcher_status[SW0_ILIM_BIT]       = sw0_current_limited;     // R2 R10
      linear_reg_status                   = 8'h00;
      linear_reg_status[LIN1_EN_BIT]      = linreg1_enabled;         // R3
      linear_reg_status[LIN0_EN_BIT]      = linreg0_enabled;         // R3
      linear_reg_status[LIN1_INVALID_BIT] = linreg1_output_invalid;  // R4 R10
      linear_reg_status[LIN0_INVALID_BIT] = linreg0_output_invalid;  // R4 R10
      linear_reg_status[LIN1_ILIM_BIT]    = linreg1_current_limited; // R5 R10
      linear_reg_status[LIN0_ILIM_BIT]    = linreg0_current_limited; // R5 R10
      top_flags                           = 8'h00;
      top_flags[PGOOD_BIT]                = power_good_flag;
      top_flags[SYNC_CLK_BIT]             = sync_clk_flag;
      top_flags[THERMAL_BIT]              = thermal_warning_flag;
      top_flags[LOAD_MEAS_BIT]            = load_meas_ready_flag;
      reset_flags                         = 8'h00;
      reset_flags[REG_RESET_BIT]          = reg_reset_flag;
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------

   logic [7:0] next_reg_rdata;
   logic       next_reg_rvalid;

   // Read mux; an unmapped address answers zero rather than stale data
   always_comb
   begin
      next_reg_rdata  = reg_rdata;
      next_reg_rvalid = reg_rd;
      if (reg_rd)
      begin
         if (reg_addr == ADDR_SWITCHER_STAT)
         begin
            next_reg_rdata = switcher_status;                  // R1 R2
         end
         else if (reg_addr == ADDR_LINREG_STAT)
         begin
            next_reg_rdata = linear_reg_status;                // R3 R4 R5
         end
         else if (reg_addr == ADDR_TOP_MASK)
         begin
            next_reg_rdata = top_event_mask;
         end
         else if (reg_addr == ADDR_RESET_MASK)
         begin
            next_reg_rdata = reset_event_mask;                 // R11
         end
         else if (reg_addr == ADDR_TOP_FLAGS)
         begin
            next_reg_rdata = top_flags;
         end
         else if (reg_addr == ADDR_RESET_FLAGS)
         begin
            next_reg_rdata = reset_flags;
         end
         else
         begin
            next_reg_rdata = READ_UNMAPPED;
         end
      end
   end

   // Read data register; holds the last answer between reads
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata  <= READ_UNMAPPED;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rdata  <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------

   logic next_irq;

   // Any flag whose mask bit is clear raises the line
   always_comb
   begin
      next_irq = (power_good_flag      && !power_good_irq_mask)       // R6 R14
              || (sync_clk_flag        && !sync_clk_irq_mask)         // R7 R14
              || (thermal_warning_flag && !thermal_warning_irq_mask)  // R8 R14
              || (load_meas_ready_flag && !load_meas_irq_mask)        // R9 R14
              || (reg_reset_flag       && !reset_irq_mask);           // R11 R14
   end

   // Registered so the pin never glitches on mask or flag updates
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= next_irq;
      end
   end

endmodule

// ===== rsm_regs_assertions.sv
// Concurrent checks on the regulator status and mask register bank.
// Assumes it is bound to rsm_regs and watches only its ports.
`timescale 1ns/1ps

module rsm_regs_chk
   import rsm_pkg::*;
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // Raw conditions, events and interrupt
   input wire logic       sw0_output_invalid,
   input wire logic       sw0_current_limited,
   input wire logic       linreg1_enabled,
   input wire logic       linreg1_output_invalid,
   input wire logic       linreg1_current_limited,
   input wire logic       linreg0_enabled,
   input wire logic       linreg0_output_invalid,
   input wire logic       linreg0_current_limited,
   input wire logic       thermal_warning_event,
   input wire logic       reg_reset_event,
   input wire logic       otp_reset_irq_mask,
   input wire logic       irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // ------------------------------------------------------------
   // Shadow of the top mask and of the OTP load
   // ------------------------------------------------------------
   logic [7:0] mask_q;
   logic [7:0] next_mask_q;
   logic       otp_q;
   logic       next_otp_q;
   logic       live;
   logic       next_live;

   // OTP is taken once, at the first edge after release
   always_comb
   begin
      next_mask_q = mask_q;
      if (reg_wr && reg_addr == ADDR_TOP_MASK)
         next_mask_q = reg_wdata;
      next_otp_q = live ? otp_q : otp_reset_irq_mask;
      next_live = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mask_q <= 8'h90;
         otp_q  <= 1'b1;
         live   <= 1'b0;
      end
      else
      begin
         mask_q <= next_mask_q;
         otp_q  <= next_otp_q;
         live   <= next_live;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   sequence rd_at(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence

   // A clear followed at once by a read, with no new event racing it
   sequence clr_then_rd;
      reg_wr && reg_addr == ADDR_TOP_FLAGS && reg_wdata[THERMAL_BIT] && !thermal_warning_event
      ##1 reg_rd && reg_addr == ADDR_TOP_FLAGS && !thermal_warning_event;
   endsequence

   chk_sw_status: assert property (rd_at(ADDR_SWITCHER_STAT) |=>
      reg_rdata == {5'h00, $past(sw0_output_invalid), 1'b0, $past(sw0_current_limited)})
      else $error("switcher status read wrong");
   chk_lin_status: assert property (rd_at(ADDR_LINREG_STAT) |=> reg_rdata == $past({linreg1_enabled,
      linreg1_output_invalid, 1'b0, linreg1_current_limited, linreg0_enabled, linreg0_output_invalid,
      1'b0, linreg0_current_limited})) else $error("linear status read wrong");
   chk_mask_read: assert property (rd_at(ADDR_TOP_MASK) |=> reg_rdata == $past(mask_q))
      else $error("top mask read wrong");
   chk_otp_mask: assert property (live ##0 rd_at(ADDR_RESET_MASK) |=> reg_rdata[0] == otp_q)
      else $error("reset mask bit not from otp");
   chk_thermal_irq: assert property (thermal_warning_event && !mask_q[THERMAL_BIT] &&
      !(reg_wr && reg_addr == ADDR_TOP_MASK) |-> ##2 irq) else $error("thermal event gave no irq");
   chk_flag_clear: assert property (clr_then_rd |=> !reg_rdata[THERMAL_BIT])
      else $error("flag survived clear");
   chk_reset_irq: assert property (reg_reset_event && live && !otp_q |-> ##2 irq)
      else $error("reset event gave no irq");
   chk_read_pulse: assert property (reg_rvalid == $past(reg_rd))
      else $error("read valid timing wrong");
endmodule

bind rsm_regs rsm_regs_chk chk_u (.ref_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
   .reg_rdata, .reg_rvalid, .sw0_output_invalid, .sw0_current_limited, .linreg1_enabled,
   .linreg1_output_invalid, .linreg1_current_limited, .linreg0_enabled, .linreg0_output_invalid,
   .linreg0_current_limited, .thermal_warning_event, .reg_reset_event, .otp_reset_irq_mask, .irq);

// ===== rsm_host.sv
// Host model driving the register port from the serial engine side.
// Assumes tasks are entered at a falling edge of ref_clk.
`timescale 1ns/1ps

module rsm_host
(
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic       reg_wr,
   output logic [7:0] reg_wdata,
   output logic       reg_rd
);
   initial
   begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // Strobes stay up so back-to-back accesses never toggle twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_rd    = 1'b0;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      reg_wr   = 1'b0;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
   endtask

   // Released bus shows inverted values so stale data cannot pass
   task automatic idle();
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(negedge ref_clk);
   endtask
endmodule

// ===== regulator_status_irq_masks_bench.sv
// Self-checking bench for the status and mask register bank.
// Assumes rsm_host drives the register port; reads are scored by a monitor.
`timescale 1ns/1ps

module regulator_status_irq_masks_bench
   import rsm_pkg::*;
;
   logic       ref_clk = 1'b0;
   logic       arst_n  = 1'b0;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] st;
   logic [7:0] m;
   logic       reg_wr;
   logic       reg_rd;
   logic       reg_rvalid;
   logic       irq;
   logic       otp;
   logic [4:0] ev;
   logic [7:0] exp_q[$];
   int         errors     = 0;
   int         num_checks = 0;
   int         cycles     = 0;
   int         seed       = 53522;
   int         bitpos[4]  = '{7, 4, 2, 0};

   always #10 ref_clk = ~ref_clk;

   rsm_host host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd));

   rsm_regs dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sw0_output_invalid(st[5]), .sw0_current_limited(st[1]), .linreg1_enabled(st[7]),
      .linreg1_output_invalid(st[6]), .linreg1_current_limited(st[4]), .linreg0_enabled(st[3]),
      .linreg0_output_invalid(st[2]), .linreg0_current_limited(st[0]), .power_good_event(ev[0]),
      .sync_clk_event(ev[1]), .thermal_warning_event(ev[2]), .load_meas_event(ev[3]),
      .reg_reset_event(ev[4]), .otp_reset_irq_mask(otp), .irq(irq));

   task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic print_verdict();
      // A read that never answered leaves its note behind
      if (exp_q.size() != 0)
      begin
         errors++;
         $display("mismatch read answers expected 0 pending seen %0d", exp_q.size());
      end
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Expected read data is queued before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.rd(a);
   endtask

   task automatic cyc(input int n);
      repeat (n) host_u.idle();
   endtask

   task automatic pulse(input int i);
      ev[i] = 1'b1;
      host_u.idle();
      ev[i] = 1'b0;
   endtask

   // ------------------------------------------------------------
   // Read monitor and hang guard
   // ------------------------------------------------------------
   always @(negedge ref_clk)
   begin
      if (reg_rvalid === 1'b1)
      begin
         if (exp_q.size() > 0)
            check8("read data", exp_q.pop_front(), reg_rdata);
         else
         begin
            errors++;
            $display("mismatch read expected none seen %h", reg_rdata);
         end
      end
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         $display("mismatch run expected done seen timeout");
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      st  = 8'h00;
      ev  = 5'h00;
      otp = 1'b0;
      repeat (20) @(negedge ref_clk);
      arst_n = 1'b1;
      check8("irq", 8'h00, {7'h00, irq});
      // The OTP bit lands at the first edge after release; read after it
      cyc(1);
      rd(ADDR_RESET_MASK, 8'h00);
      rd(ADDR_TOP_MASK, 8'h90);
      rd(8'h40, 8'h00);
      host_u.wr(ADDR_RESET_MASK, 8'hff);
      rd(ADDR_RESET_MASK, 8'hfe);
      // Status must track its inputs whatever the mask holds
      for (int i = 0; i < 8; i++)
      begin
         m = $random(seed);
         host_u.wr(ADDR_TOP_MASK, m);
         rd(ADDR_TOP_MASK, m);
         host_u.wr(ADDR_LINREG_STAT, 8'hff);
         host_u.wr(ADDR_SWITCHER_STAT, 8'hff);
         st = $random(seed);
         rd(ADDR_SWITCHER_STAT, {5'h00, st[5], 1'b0, st[1]});
         rd(ADDR_LINREG_STAT, st & 8'hdd);
      end
      // Each top event: suppressed while masked, latched, then cleared
      for (int i = 0; i < 4; i++)
      begin
         host_u.wr(ADDR_TOP_MASK, 8'hff);
         pulse(i);
         cyc(3);
         check8("irq masked", 8'h00, {7'h00, irq});
         rd(ADDR_TOP_FLAGS, 8'h01 << bitpos[i]);
         host_u.wr(ADDR_TOP_MASK, ~(8'h01 << bitpos[i]));
         cyc(2);
         check8("irq unmasked", 8'h01, {7'h00, irq});
         pulse(i);
         host_u.wr(ADDR_TOP_FLAGS, 8'h01 << bitpos[i]);
         rd(ADDR_TOP_FLAGS, 8'h00);
         cyc(2);
         check8("irq cleared", 8'h00, {7'h00, irq});
      end
      // OTP left the register-reset event unmasked
      pulse(4);
      cyc(2);
      check8("irq reset event", 8'h01, {7'h00, irq});
      rd(ADDR_RESET_FLAGS, 8'h01);
      host_u.wr(ADDR_RESET_FLAGS, 8'h01);
      cyc(3);
      check8("irq reset cleared", 8'h00, {7'h00, irq});
      // Mid-run reset with the OTP bit set: register-reset event stays masked
      otp    = 1'b1;
      arst_n = 1'b0;
      cyc(3);
      arst_n = 1'b1;
      cyc(2);
      rd(ADDR_RESET_MASK, 8'h01);
      rd(ADDR_TOP_MASK, 8'h90);
      host_u.wr(ADDR_RESET_MASK, 8'h00);
      rd(ADDR_RESET_MASK, 8'h01);
      pulse(4);
      cyc(2);
      check8("irq otp masked", 8'h00, {7'h00, irq});
      rd(ADDR_RESET_FLAGS, 8'h01);
      cyc(2);
      print_verdict();
   end
endmodule
